// [rtl/cdc_status_error_flags.sv]
// Status and error-flag register bank of a multi-channel capacitance converter
// Function
// R1 - Status bits 15:14 name the channel of the latest flag or error.
// R2 - Flags stay latched until status read or read of the named channel's data.
// R3 - Bit 11 records a watchdog timeout since the last status read.
// R4 - Bit 10 records an amplitude-high warning since the last status read.
// R5 - Bit 9 records an amplitude-low warning since the last status read.
// R6 - Single-channel mode: bit 6 sets on every new result.
// R7 - Sequential mode: bit 6 sets once all active channels have new results.
// R8 - Bits 3..0 show unread results, channel 0 at bit 3.
// R9 - Channels 2 and 3 exist only on four-channel variants.
// R10 - Reserved status bits read zero and ignore writes.
// R11 - Timeout-to-interrupt enable gates watchdog status bit and interrupt pin.
// R12 - Ready-to-interrupt enable gates data-ready bit and interrupt pin.
// R13 - Config bits 13..11 copy faults into the channel's result word error fields.
`timescale 1ns/1ps
`include "cdc_flags_regs.svh"

module cdc_status_error_flags
   import cdc_flags_pkg::*;
#(
   parameter int NUM_CHAN = 4
)(
   input  wire logic        i_core_clk,
   input  wire logic        i_rst_n,
   input  wire logic [7:0]  i_reg_addr,
   input  wire logic        i_reg_rd,
   input  wire logic        i_reg_wr,
   input  wire logic [15:0] i_reg_wdata,
   input  wire logic [3:0]  i_data_rd,
   input  wire logic        i_conv_done,
   input  wire logic [1:0]  i_conv_chan,
   input  wire logic        i_seq_mode,
   input  wire logic [3:0]  i_active_mask,
   input  fault_evt_t       i_fault,
   output logic      [15:0] o_reg_rdata,
   output logic      [3:0]  o_word_wd,
   output logic      [3:0]  o_word_aw,
   output logic             o_irq_out_n
);

   // Channels present on this variant; two-channel parts hide 2 and 3
   localparam logic [3:0] CHAN_PRESENT = (NUM_CHAN > 2) ? 4'hF : 4'h3;

   status_t    st_r;
   status_t    st_nxt;
   logic [3:0] seen_r;
   logic [3:0] seen_nxt;
   logic [3:0] pend_nxt;
   logic [3:0] wd_word_r;
   logic [3:0] wd_word_nxt;
   logic [3:0] aw_word_r;
   logic [3:0] aw_word_nxt;
   logic [15:0] rdata_r;
   logic [15:0] rdata_nxt;
   fault_cfg_t cfg;
   logic [15:0] cfg_rdata;
   logic       st_rd;
   logic       cfg_wr;
   logic       chan_ok;
   logic       fault_live;
   logic       wd_live;
   logic       err_data_rd;
   logic [3:0] done_vec;
   logic [3:0] seq_need;
   logic       seq_full;
   logic       result_ready_flag_set;

   fault_report_config_reg u_cfg (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_wr       (cfg_wr),
      .i_wdata    (i_reg_wdata),
      .o_cfg      (cfg),
      .o_rdata    (cfg_rdata)
   );

   // Access decode; status is read-only so writes there are dropped
   assign st_rd  = i_reg_rd && (i_reg_addr == `STATUS_OFFSET);
   assign cfg_wr = i_reg_wr && (i_reg_addr == `FAULT_CFG_OFFSET);  // R10

   // Event qualification; events from absent channels are ignored
   assign chan_ok    = CHAN_PRESENT[i_fault.chan];                         // R9
   assign wd_live    = i_fault.wd && cfg.timeout_to_irq_enable && chan_ok; // R11
   assign fault_live = (wd_live || i_fault.ah || i_fault.al) && chan_ok;
   assign err_data_rd = i_data_rd[st_r.fault_source_channel];              // R2

   // One-hot result completion, restricted to present channels
   always_comb begin
      done_vec = 4'h0;
      if (i_conv_done && CHAN_PRESENT[i_conv_chan]) begin
         done_vec[i_conv_chan] = 1'b1;
      end
   end

   // Sequence completes once every active channel has reported
   assign seq_need = i_active_mask & CHAN_PRESENT;
   assign seq_full = ((seen_r | done_vec) & seq_need) == seq_need;
   assign result_ready_flag_set = cfg.ready_to_irq_enable && (|done_vec) &&
                     (!i_seq_mode || seq_full);                            // R6 R7 R12

   // Status next state; an arriving event wins over a read clear
   always_comb begin
      st_nxt = st_r;
      seen_nxt = seen_r;
      if (st_rd || err_data_rd) begin                                      // R2
         st_nxt.watchdog_timeout_flag  = 1'b0;                             // R3
         st_nxt.amplitude_high_warning = 1'b0;                             // R4
         st_nxt.amplitude_low_warning  = 1'b0;                             // R5
      end
      if (st_rd) begin
         st_nxt.result_ready_flag = 1'b0;
      end
      if (fault_live) begin
         st_nxt.fault_source_channel = i_fault.chan;                       // R1
      end
      if (wd_live) begin
         st_nxt.watchdog_timeout_flag = 1'b1;                              // R3 R11
      end
      if (i_fault.ah && chan_ok) begin
         st_nxt.amplitude_high_warning = 1'b1;                             // R4
      end
      if (i_fault.al && chan_ok) begin
         st_nxt.amplitude_low_warning = 1'b1;                              // R5
      end
      if (result_ready_flag_set) begin
         st_nxt.result_ready_flag = 1'b1;                                  // R6 R7
      end
      // Sequence tracking restarts when the set is complete or mode leaves
      if (!i_seq_mode || (|done_vec && seq_full)) begin
         seen_nxt = 4'h0;
      end else begin
         seen_nxt = seen_r | done_vec;
      end
      st_nxt.pending_result = pend_nxt;                                    // R8
      st_nxt.rsv_13_12 = 2'h0;                                             // R10
      st_nxt.rsv_8_7   = 2'h0;                                             // R10
      st_nxt.rsv_5_4   = 2'h0;                                             // R10
   end

   // Per-channel pending and result-word error bits; set beats clear
   // Kept in their own nets so the status process stays the only writer of st_nxt
   for (genvar c = 0; c < 4; c++) begin : g_chan
      assign pend_nxt[3 - c] = CHAN_PRESENT[c] &&
         (done_vec[c] || (st_r.pending_result[3 - c] && !i_data_rd[c]));     // R8 R9
      assign wd_word_nxt[c] = CHAN_PRESENT[c] &&
         ((i_fault.wd && cfg.timeout_to_result_word && i_fault.chan == 2'(c)) ||
          (wd_word_r[c] && !i_data_rd[c]));                                 // R13
      assign aw_word_nxt[c] = CHAN_PRESENT[c] &&
         ((((i_fault.ah && cfg.high_amp_to_result_word) ||
            (i_fault.al && cfg.low_amp_to_result_word)) && i_fault.chan == 2'(c)) ||
          (aw_word_r[c] && !i_data_rd[c]));                                 // R13
   end

   // Read data captured before the read clear takes effect
   always_comb begin
      rdata_nxt = rdata_r;
      if (i_reg_rd) begin
         unique case (i_reg_addr)
            `STATUS_OFFSET:    rdata_nxt = st_r;
            `FAULT_CFG_OFFSET: rdata_nxt = cfg_rdata;
            default:           rdata_nxt = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         st_r      <= status_t'(`STATUS_RESET);
         seen_r    <= 4'h0;
         wd_word_r <= 4'h0;
         aw_word_r <= 4'h0;
         rdata_r   <= 16'h0000;
      end else begin
         st_r      <= st_nxt;
         seen_r    <= seen_nxt;
         wd_word_r <= wd_word_nxt;
         aw_word_r <= aw_word_nxt;
         rdata_r   <= rdata_nxt;
      end
   end

   // Pin pulled low while a reportable flag is latched
   assign o_irq_out_n = !(st_r.watchdog_timeout_flag || st_r.result_ready_flag);  // R11 R12
   assign o_reg_rdata = rdata_r;
   assign o_word_wd   = wd_word_r;
   assign o_word_aw   = aw_word_r;

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);

   chan_latched_a: assert property (fault_live |=> st_r.fault_source_channel == $past(i_fault.chan))  // R1
      else $error("fault channel not captured");
   flag_hold_a: assert property (st_r.amplitude_high_warning && !st_rd && !err_data_rd |=>
                                 st_r.amplitude_high_warning)                                         // R2
      else $error("amplitude high flag dropped early");
   wd_set_a: assert property (wd_live |=> st_r.watchdog_timeout_flag)                                 // R3
      else $error("watchdog flag not set");
   wd_clear_a: assert property (st_rd && !i_fault.wd ##1 1 |-> !st_r.watchdog_timeout_flag)           // R3
      else $error("watchdog flag survived status read");
   ah_set_a: assert property (i_fault.ah && chan_ok |=> st_r.amplitude_high_warning)                  // R4
      else $error("amplitude high flag not set");
   al_set_a: assert property (i_fault.al && chan_ok |=> st_r.amplitude_low_warning)                   // R5
      else $error("amplitude low flag not set");
   single_ready_a: assert property (!i_seq_mode && i_conv_done && cfg.ready_to_irq_enable &&
                                    CHAN_PRESENT[i_conv_chan] |=> st_r.result_ready_flag)             // R6
      else $error("ready flag missing in single mode");
   seq_ready_a: assert property (i_seq_mode && !seq_full && !st_r.result_ready_flag |=>
                                 !st_r.result_ready_flag)                                             // R7
      else $error("ready flag before sequence complete");
   pending_map_a: assert property (done_vec[0] |=> st_r.pending_result[3] ##1 1)                      // R8
      else $error("channel 0 pending bit not at bit 3");
   absent_chan_a: assert property (NUM_CHAN <= 2 |-> st_r.pending_result[1:0] == 2'h0)                // R9
      else $error("absent channel reported");
   reserved_zero_a: assert property (i_reg_rd && i_reg_addr == `STATUS_OFFSET |=>
                                     (o_reg_rdata & 16'h31B0) == 16'h0000)                            // R10
      else $error("reserved status bits not zero");
   wd_gate_a: assert property (!cfg.timeout_to_irq_enable && !st_r.watchdog_timeout_flag |=>
                               !st_r.watchdog_timeout_flag)                                           // R11
      else $error("watchdog reported while disabled");
   irq_pin_a: assert property (st_r.result_ready_flag |-> !o_irq_out_n)                               // R12
      else $error("interrupt pin not asserted on ready");
   word_wd_a: assert property (i_fault.wd && cfg.timeout_to_result_word && chan_ok |=>
                               o_word_wd[$past(i_fault.chan)])                                        // R13
      else $error("timeout not copied to result word");

   seq_done_c:   cover property (i_seq_mode ##0 result_ready_flag_set);
   status_rd_c:  cover property (st_r.watchdog_timeout_flag ##1 st_rd);
   data_clr_c:   cover property (st_r.amplitude_low_warning && err_data_rd);
   race_c:       cover property (st_rd && i_fault.ah);

endmodule : cdc_status_error_flags

// [rtl/cdc_flags_regs.svh]
// Register offsets, field positions and reset values for the status and fault-report registers
`ifndef CDC_FLAGS_REGS_SVH
`define CDC_FLAGS_REGS_SVH

`define STATUS_OFFSET        8'h18
`define FAULT_CFG_OFFSET     8'h19

`define STATUS_RESET         16'h0000
`define FAULT_CFG_RESET      16'h0000

`define ST_CHAN_HI           15
`define ST_CHAN_LO           14
`define ST_WD_BIT            11
`define ST_AH_BIT            10
`define ST_AL_BIT            9
`define ST_RESULT_READY_FLAG_BIT          6
`define ST_PEND_HI           3

`define CFG_WD_WORD_BIT      13
`define CFG_AH_WORD_BIT      12
`define CFG_AL_WORD_BIT      11
`define CFG_WD_IRQ_BIT       5
`define CFG_RESULT_READY_FLAG_IRQ_BIT     0

`endif

// [rtl/cdc_flags_pkg.sv]
// Types shared by the status flag block and its configuration register
package cdc_flags_pkg;

   // Status register image, bit 15 first
   typedef struct packed {
      logic [1:0] fault_source_channel;
      logic [1:0] rsv_13_12;
      logic       watchdog_timeout_flag;
      logic       amplitude_high_warning;
      logic       amplitude_low_warning;
      logic [1:0] rsv_8_7;
      logic       result_ready_flag;
      logic [1:0] rsv_5_4;
      logic [3:0] pending_result;        // Bit 3 is channel 0
   } status_t;

   // Decoded fault-report configuration bits
   typedef struct packed {
      logic timeout_to_result_word;
      logic high_amp_to_result_word;
      logic low_amp_to_result_word;
      logic timeout_to_irq_enable;
      logic ready_to_irq_enable;
   } fault_cfg_t;

   // Fault event from the conversion engine
   typedef struct packed {
      logic       wd;
      logic       ah;
      logic       al;
      logic [1:0] chan;
   } fault_evt_t;

endpackage : cdc_flags_pkg

// [rtl/fault_report_config_reg.sv]
// Fault-report configuration register with reserved bits held at zero
`timescale 1ns/1ps
`include "cdc_flags_regs.svh"

module fault_report_config_reg
   import cdc_flags_pkg::*;
(
   input  wire logic        i_core_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_wr,
   input  wire logic [15:0] i_wdata,
   output fault_cfg_t       o_cfg,
   output logic      [15:0] o_rdata
);

   fault_cfg_t cfg_r;
   fault_cfg_t cfg_nxt;

   // Only documented bits are stored; reserved writes are dropped
   always_comb begin
      cfg_nxt = cfg_r;
      if (i_wr) begin
         cfg_nxt.timeout_to_result_word  = i_wdata[`CFG_WD_WORD_BIT];
         cfg_nxt.high_amp_to_result_word = i_wdata[`CFG_AH_WORD_BIT];
         cfg_nxt.low_amp_to_result_word  = i_wdata[`CFG_AL_WORD_BIT];
         cfg_nxt.timeout_to_irq_enable   = i_wdata[`CFG_WD_IRQ_BIT];
         cfg_nxt.ready_to_irq_enable     = i_wdata[`CFG_RESULT_READY_FLAG_IRQ_BIT];
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         cfg_r <= fault_cfg_t'(5'h00);
      end else begin
         cfg_r <= cfg_nxt;
      end
   end

   // Read image rebuilt from the stored bits
   always_comb begin
      o_rdata                      = `FAULT_CFG_RESET;
      o_rdata[`CFG_WD_WORD_BIT]    = cfg_r.timeout_to_result_word;
      o_rdata[`CFG_AH_WORD_BIT]    = cfg_r.high_amp_to_result_word;
      o_rdata[`CFG_AL_WORD_BIT]    = cfg_r.low_amp_to_result_word;
      o_rdata[`CFG_WD_IRQ_BIT]     = cfg_r.timeout_to_irq_enable;
      o_rdata[`CFG_RESULT_READY_FLAG_IRQ_BIT]   = cfg_r.ready_to_irq_enable;
   end

   assign o_cfg = cfg_r;

endmodule : fault_report_config_reg

// [bench/host_reg_model.sv]
// Host model driving the register bus and the result-register read strobes
`timescale 1ns/1ps

module host_reg_model (
   input  wire logic        i_core_clk,
   input  wire logic [15:0] i_rdata,
   output logic      [7:0]  o_addr,
   output logic             o_rd,
   output logic             o_wr,
   output logic      [15:0] o_wdata,
   output logic      [3:0]  o_data_rd
);
   // Idle bus from time zero
   initial begin
      o_addr = 8'h00;
      o_rd = 1'b0;
      o_wr = 1'b0;
      o_wdata = 16'h0000;
      o_data_rd = 4'h0;
   end

   // Read strobe for one cycle, data taken one cycle later
   task rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge i_core_clk);
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_core_clk);
      o_rd <= 1'b0;
      #1 d = i_rdata;
   endtask : rd

   // Write strobe for one cycle
   task wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge i_core_clk);
      o_addr <= a;
      o_wdata <= v;
      o_wr <= 1'b1;
      @(posedge i_core_clk);
      o_wr <= 1'b0;
   endtask : wr

   // Result-register read of one channel
   task dr(input int ch);
      @(posedge i_core_clk);
      o_data_rd <= 4'h1 << ch;
      @(posedge i_core_clk);
      o_data_rd <= 4'h0;
   endtask : dr
endmodule : host_reg_model

// [bench/test_cdc_status_error_flags.sv]
// Self-checking bench with a behavioural flag model
`timescale 1ns/1ps

module test_cdc_status_error_flags;
   import cdc_flags_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        done = 1'b0;
   logic [1:0]  cch = 2'h0;
   logic        seq = 1'b0;
   logic [3:0]  mask = 4'hF;
   fault_evt_t  flt = '0;
   logic [7:0]  addr;
   logic        rd, wr;
   logic [15:0] wdat, rdata, rdata2, d, mcfg;
   logic [3:0]  drd, w_wd, w_aw, w_wd2, w_aw2, pend, mww, mwa, seen;
   logic        irq_n;
   logic        mw, mh, ml, mr;
   logic [1:0]  mch;
   int          fails = 0, checked = 0, seed = 32'h54E8C1D9, r;

   always #5 clk = ~clk;

   cdc_status_error_flags u_cdc_status_error_flags (.i_core_clk(clk), .i_rst_n(rst_n), .i_reg_addr(addr),
      .i_reg_rd(rd), .i_reg_wr(wr), .i_reg_wdata(wdat), .i_data_rd(drd), .i_conv_done(done), .i_conv_chan(cch),
      .i_seq_mode(seq), .i_active_mask(mask), .i_fault(flt), .o_reg_rdata(rdata), .o_word_wd(w_wd),
      .o_word_aw(w_aw), .o_irq_out_n(irq_n));
   // Two-channel variant on the same stimulus; channels 2 and 3 must stay silent there
   cdc_status_error_flags #(.NUM_CHAN(2)) u_cdc_status_error_flags_two (.i_core_clk(clk), .i_rst_n(rst_n),
      .i_reg_addr(addr), .i_reg_rd(rd), .i_reg_wr(wr), .i_reg_wdata(wdat), .i_data_rd(drd), .i_conv_done(done),
      .i_conv_chan(cch), .i_seq_mode(seq), .i_active_mask(mask), .i_fault(flt), .o_reg_rdata(rdata2),
      .o_word_wd(w_wd2), .o_word_aw(w_aw2), .o_irq_out_n());
   host_reg_model u_host_reg_model (.i_core_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_rd(rd), .o_wr(wr),
      .o_wdata(wdat), .o_data_rd(drd));

   task chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // Fault pulse; model keeps gating by the config bits
   task fault(input logic w, input logic h, input logic l, input logic [1:0] ch);
      @(posedge clk);
      flt <= '{wd: w, ah: h, al: l, chan: ch};
      @(posedge clk);
      flt <= '0;
      mw |= w & mcfg[5];
      mh |= h;
      ml |= l;
      if (h | l | (w & mcfg[5])) mch = ch;
      mww[ch] |= w & mcfg[13];
      mwa[ch] |= (h & mcfg[12]) | (l & mcfg[11]);
   endtask : fault

   // New result; sequential mode waits for the whole mask
   task conv(input logic [1:0] ch);
      @(posedge clk);
      done <= 1'b1;
      cch <= ch;
      @(posedge clk);
      done <= 1'b0;
      pend[ch] = 1'b1;
      seen[ch] = 1'b1;
      if (!seq || (seen & mask) == mask) begin
         mr |= mcfg[0];
         seen = 4'h0;
      end
   endtask : conv

   task drd_ch(input int ch);
      u_host_reg_model.dr(ch);
      pend[ch] = 1'b0;
      mww[ch] = 1'b0;
      mwa[ch] = 1'b0;
      if (ch == mch) {mw, mh, ml} = 3'b000;
   endtask : drd_ch

   // Pin and result-word state, then status image; the read clears flags
   // Waits for the falling edge so the last event edge has settled
   task st;
      @(negedge clk);
      chk({15'h0, irq_n}, {15'h0, !(mw | mr)});
      chk({8'h0, w_wd, w_aw}, {8'h0, mww, mwa});
      u_host_reg_model.rd(8'h18, d);
      chk(d, {mch, 2'b00, mw, mh, ml, 2'b00, mr, 2'b00, pend[0], pend[1], pend[2], pend[3]});
      chk({13'h0, rdata2[15], rdata2[1:0]}, 16'h0000);
      chk({12'h0, rdata2[3:2], w_wd2[3:2]}, {12'h0, pend[0], pend[1], 2'b00});
      chk({14'h0, w_aw2[3:2]}, 16'h0000);
      {mw, mh, ml, mr} = 4'h0;
   endtask : st

   task stop_test;
      $display("comparisons %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test

   // Watchdog well beyond the expected run
   initial begin
      #200000;
      fails++;
      stop_test();
   end

   initial begin
      {mw, mh, ml, mr, mch, pend, mww, mwa, seen, mcfg} = '0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      st();
      u_host_reg_model.rd(8'h19, d);
      chk(d, 16'h0000);
      u_host_reg_model.rd(8'h20, d);
      chk(d, 16'h0000);
      u_host_reg_model.wr(8'h19, 16'h2000);
      mcfg = 16'h2000;
      fault(1'b1, 1'b0, 1'b0, 2'd0);
      conv(2'd3);
      st();
      drd_ch(3);
      drd_ch(0);
      u_host_reg_model.wr(8'h19, 16'hFFFF);
      u_host_reg_model.rd(8'h19, d);
      chk(d, 16'h3821);
      mcfg = 16'h3821;
      fault(1'b1, 1'b0, 1'b0, 2'd2);
      drd_ch(2);
      st();
      fault(1'b0, 1'b1, 1'b0, 2'd1);
      fault(1'b0, 1'b0, 1'b1, 2'd3);
      u_host_reg_model.wr(8'h18, 16'hFFFF);
      st();
      st();
      conv(2'd1);
      st();
      drd_ch(1);
      @(posedge clk);
      seq <= 1'b1;
      mask <= 4'h5;
      conv(2'd0);
      st();
      conv(2'd2);
      st();
      @(posedge clk);
      seq <= 1'b0;
      mask <= 4'hF;
      repeat (60) begin
         r = $random(seed);
         case (r[1:0])
            2'd0: fault(r[2], r[3], !(r[2] | r[3]) | r[4], r[6:5]);
            2'd1: conv(r[6:5]);
            2'd2: drd_ch(r[6:5]);
            default: st();
         endcase
      end
      st();
      stop_test();
   end
endmodule : test_cdc_status_error_flags
